// >>> logic/hcp_pkg.sv
`default_nettype none

package hcp_pkg;

    localparam int BYTE_W = 8;
    localparam int CNT_W = 4;
    localparam int SYNC_W = 6;

    // bit counter values: last bit of a byte, a whole byte seen
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;

    // fixed part of the two-wire target address around the strap bits
    localparam logic [3:0] I2C_ADDR_HI = 4'h2;
    localparam logic I2C_ADDR_B0 = 1'b0;
    localparam logic RW_WRITE = 1'b0;

    // command code window of the core decoder
    localparam logic [7:0] CMD_BASE = 8'h01;
    localparam logic [7:0] CMD_COUNT = 8'h19;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // gray-coded along idle, address, ack, data, ack
    typedef enum logic [2:0] {
        HCP_IDLE = 3'b000,
        HCP_ADDR = 3'b001,
        HCP_AACK = 3'b011,
        HCP_DATA = 3'b010,
        HCP_DACK = 3'b110,
        HCP_RDAT = 3'b111,
        HCP_WAIT = 3'b100
    } hcp_i2c_st_t;

endpackage

`default_nettype wire

// >>> logic/hcp_sync.sv
`default_nettype none

module hcp_sync #(
    parameter int W = 1
) (
    input wire logic mclk, // sampling clock
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    // no reset: the pair only carries levels, and reset outlasts two edges
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk) begin
        meta_r <= d;
        q <= meta_r;
    end

endmodule

`default_nettype wire

// >>> logic/hcp_host_port.sv
`default_nettype none
// Contract
// - select pin sampled during reset; low picks two-wire, high four-wire.
// - every transfer is made of one-byte packets of 8 bits.
// - data pin open-drain in two-wire mode, push-pull in four-wire mode.
// - address bits 1 and 2 come from the two strap pins.
// - one data byte per two-wire transaction; further bytes are refused.
// - two-wire port works at 100 kbit/s and 400 kbit/s.
// - four-wire mode shifts a byte in while shifting a byte out.
// - four-wire bits go MSB first, only while enable is low.
// - input bit captured on each rising serial clock edge.
// - output updated on falling clock edges; MSB on enable's falling edge.
// - short frames are right-aligned and delivered when enable rises.
// - long frames keep only the last 8 bits received.
// - after the LSB, the output echoes received bits, MSB first.
// - received bytes become commands out of a set of 25 functions.

module hcp_host_port (
    input wire logic mclk, // core clock, 100 MHz
    input wire logic reset_n, // reset, active low; synchronous in the core domain, asynchronous for the frame marker
    input wire logic host_bus_select, // bus select pin
    input wire logic host_clk, // two-wire clock / four-wire serial clock
    input wire logic host_data_i, // data pin level seen from outside
    output logic host_data_o, // data pin drive value
    output logic host_data_oe_n, // data pin drive enable, low drives
    input wire logic serial_data_in, // serial input / address strap bit 1
    input wire logic serial_enable_n, // serial enable / address strap bit 2
    input wire logic [7:0] rsp_byte, // byte the core offers for reading
    output logic cmd_valid, // one-cycle pulse: new byte from host
    output logic [7:0] cmd_byte, // byte received from host
    output logic cmd_known, // byte falls within the command window
    output logic [7:0] cmd_func, // function index of a known command
    output logic mode_4wire // selected bus, high for four-wire
);
    ////////////////////////////////////////////////////////////////////////
    // link-clock domain: four-wire shifter
    logic [7:0] rx_sh_r;
    logic [3:0] rc_r;
    logic [3:0] fc_r;
    logic tog_r;
    logic out_r;
    logic [7:0] rd_hold_r;

    // rising-edge counter, cleared while enable is high
    always_ff @(posedge host_clk or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            rc_r <= hcp_pkg::BIT_ZERO;
        end else if (rc_r != hcp_pkg::BIT_FULL) begin
            rc_r <= rc_r + hcp_pkg::BIT_ONE;
        end
    end

    // not cleared by enable: the byte must survive until the core takes it
    always_ff @(posedge host_clk) begin
        if (!serial_enable_n) begin
            if (rc_r == hcp_pkg::BIT_ZERO) begin
                rx_sh_r <= {7'h00, serial_data_in};
            end else begin
                rx_sh_r <= {rx_sh_r[6:0], serial_data_in};
            end
        end
    end

    // frame marker toggles on the first bit of each frame
    always_ff @(posedge host_clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_r <= 1'b0;
        end else if (!serial_enable_n && rc_r == hcp_pkg::BIT_ZERO) begin
            tog_r <= ~tog_r;
        end
    end

    always_ff @(negedge host_clk or posedge serial_enable_n) begin
        if (serial_enable_n) begin
            fc_r <= hcp_pkg::BIT_ZERO;
        end else if (fc_r != hcp_pkg::BIT_FULL) begin
            fc_r <= fc_r + hcp_pkg::BIT_ONE;
        end
    end

    always_ff @(negedge host_clk) begin
        if (fc_r < hcp_pkg::BIT_LAST) begin
            out_r <= rd_hold_r[3'(hcp_pkg::BIT_LAST - fc_r - hcp_pkg::BIT_ONE)];
        end else begin
            out_r <= rx_sh_r[7];
        end
    end

    // before the first falling edge the MSB stands from enable's fall on
    logic tx_bit;
    assign tx_bit = (fc_r == hcp_pkg::BIT_ZERO) ? rd_hold_r[7] : out_r;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling into the core domain
    logic [hcp_pkg::SYNC_W-1:0] sync_q;
    logic sel_s, scl_s, sda_s, din_s, en_s, tog_s;

    hcp_sync #(.W(hcp_pkg::SYNC_W)) u_sync (
        .mclk(mclk),
        .d({host_bus_select, host_clk, host_data_i, serial_data_in, serial_enable_n, tog_r}),
        .q(sync_q)
    );
    assign {sel_s, scl_s, sda_s, din_s, en_s, tog_s} = sync_q;

    logic mode_r;
    logic [1:0] strap_r;

    // straps and mode follow the pins while reset is held, then freeze
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_r <= sel_s;
            strap_r <= {en_s, din_s};
        end
    end
    assign mode_4wire = mode_r;

    logic [6:0] my_addr;
    assign my_addr = {hcp_pkg::I2C_ADDR_HI, strap_r, hcp_pkg::I2C_ADDR_B0};

    ////////////////////////////////////////////////////////////////////////
    // two-wire slave, oversampled; 100 MHz gives 125 samples per fast half bit
    logic scl_q, sda_q, en_q, tog_q;

    always_ff @(posedge mclk) begin
        scl_q <= scl_s;
        sda_q <= sda_s;
        en_q <= en_s;
        tog_q <= tog_s;
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_c = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

    hcp_pkg::hcp_i2c_st_t st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic sda_low_r;
    logic i2c_got;

    assign i2c_got = (st_r == hcp_pkg::HCP_DATA) && (bit_r == hcp_pkg::BIT_FULL) && scl_fall;

    always_ff @(posedge mclk) begin
        if (!reset_n || mode_r) begin
            st_r <= hcp_pkg::HCP_IDLE;
            bit_r <= hcp_pkg::BIT_ZERO;
            sh_r <= hcp_pkg::BYTE_ZERO;
            sda_low_r <= 1'b0;
        end else if (stop_c) begin
            st_r <= hcp_pkg::HCP_IDLE;
            sda_low_r <= 1'b0;
        end else if (start_c) begin
            st_r <= hcp_pkg::HCP_ADDR;
            bit_r <= hcp_pkg::BIT_ZERO;
            sda_low_r <= 1'b0;
        end else begin
            case (st_r)
                hcp_pkg::HCP_ADDR, hcp_pkg::HCP_DATA: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], sda_s};
                        bit_r <= bit_r + hcp_pkg::BIT_ONE;
                    end else if (scl_fall && bit_r == hcp_pkg::BIT_FULL) begin
                        if (st_r == hcp_pkg::HCP_DATA) begin
                            st_r <= hcp_pkg::HCP_DACK;
                            sda_low_r <= 1'b1;
                        end else if (sh_r[7:1] == my_addr) begin
                            st_r <= hcp_pkg::HCP_AACK;
                            sda_low_r <= 1'b1;
                        end else begin
                            st_r <= hcp_pkg::HCP_WAIT;
                        end
                    end
                end
                hcp_pkg::HCP_AACK: begin
                    if (scl_fall) begin
                        bit_r <= hcp_pkg::BIT_ZERO;
                        if (sh_r[0] == hcp_pkg::RW_WRITE) begin
                            st_r <= hcp_pkg::HCP_DATA;
                            sda_low_r <= 1'b0;
                        end else begin
                            st_r <= hcp_pkg::HCP_RDAT;
                            sda_low_r <= ~rd_hold_r[7];
                            sh_r <= {rd_hold_r[6:0], 1'b1};
                        end
                    end
                end
                hcp_pkg::HCP_RDAT: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + hcp_pkg::BIT_ONE;
                        if (bit_r == hcp_pkg::BIT_LAST) begin
                            st_r <= hcp_pkg::HCP_WAIT;
                            sda_low_r <= 1'b0;
                        end else begin
                            sda_low_r <= ~sh_r[7];
                            sh_r <= {sh_r[6:0], 1'b1};
                        end
                    end
                end
                hcp_pkg::HCP_DACK: begin
                    // a second data byte is never acknowledged
                    if (scl_fall) begin
                        st_r <= hcp_pkg::HCP_WAIT;
                        sda_low_r <= 1'b0;
                    end
                end
                default: begin
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low; push-pull in four-wire mode
    always_comb begin
        if (mode_r) begin
            host_data_o = tx_bit;
            host_data_oe_n = 1'b0;
        end else begin
            host_data_o = 1'b0;
            host_data_oe_n = ~sda_low_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read byte hold and command hand-off
    logic link_idle;
    logic fw_got;
    logic tog_seen_r;
    assign link_idle = mode_r ? (en_s & en_q) : (st_r == hcp_pkg::HCP_IDLE);
    // rx_sh_r is quiet while enable stays high, so it is taken as a word here
    assign fw_got = mode_r && en_s && !en_q && (tog_s != tog_q || tog_s != tog_seen_r);

    // the byte handed to the link changes only between frames
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_hold_r <= hcp_pkg::BYTE_ZERO;
        end else if (link_idle) begin
            rd_hold_r <= rsp_byte;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tog_seen_r <= tog_s;
        end else if (en_s && !en_q) begin
            tog_seen_r <= tog_s;
        end
    end

    logic [7:0] rx_byte;
    assign rx_byte = mode_r ? rx_sh_r : sh_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cmd_valid <= 1'b0;
            cmd_byte <= hcp_pkg::BYTE_ZERO;
            cmd_known <= 1'b0;
            cmd_func <= hcp_pkg::BYTE_ZERO;
        end else begin
            cmd_valid <= fw_got | i2c_got;
            if (fw_got || i2c_got) begin
                cmd_byte <= rx_byte;
                cmd_func <= rx_byte - hcp_pkg::CMD_BASE;
                cmd_known <= (rx_byte >= hcp_pkg::CMD_BASE)
                    && (rx_byte - hcp_pkg::CMD_BASE < hcp_pkg::CMD_COUNT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_mode_frozen: assert property (@(posedge mclk) disable iff (!reset_n)
        $stable(mode_r) && $stable(strap_r))
        else $error("bus mode or strap changed after reset");

    chk_push_pull: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_r && fc_r == hcp_pkg::BIT_ZERO) |-> (!host_data_oe_n && host_data_o == rd_hold_r[7]))
        else $error("four-wire output not driven with read MSB");

    chk_open_drain: assert property (@(posedge mclk) disable iff (!reset_n)
        (!mode_r && !host_data_oe_n) |-> !host_data_o)
        else $error("two-wire pin driven high");

    chk_addr_ack: assert property (@(posedge mclk) disable iff (!reset_n)
        (st_r == hcp_pkg::HCP_ADDR && scl_fall && bit_r == hcp_pkg::BIT_FULL
         && sh_r[7:1] == my_addr && !start_c && !stop_c)
        |=> (st_r == hcp_pkg::HCP_AACK && !host_data_oe_n))
        else $error("own address not acknowledged");

    chk_one_byte: assert property (@(posedge mclk) disable iff (!reset_n)
        (st_r == hcp_pkg::HCP_WAIT) |-> (host_data_oe_n && !i2c_got))
        else $error("extra byte accepted");

    chk_i2c_deliver: assert property (@(posedge mclk) disable iff (!reset_n)
        (i2c_got && !start_c && !stop_c) |=> (cmd_valid && cmd_byte == $past(sh_r)
        && st_r == hcp_pkg::HCP_DACK) ##1 !cmd_valid)
        else $error("two-wire byte not delivered once");

    chk_fw_deliver: assert property (@(posedge mclk) disable iff (!reset_n)
        fw_got |=> (cmd_valid && cmd_byte == rx_sh_r))
        else $error("four-wire byte not delivered on enable rise");

    chk_cmd_window: assert property (@(posedge mclk) disable iff (!reset_n)
        (cmd_valid && cmd_known) |-> (cmd_func < hcp_pkg::CMD_COUNT))
        else $error("known command outside the window");

    chk_shift_in: assert property (@(posedge host_clk) disable iff (serial_enable_n)
        // two rises seen in this frame: the previous rise shifted, never a frame start
        (rc_r > hcp_pkg::BIT_ONE) |-> (rx_sh_r[0] == $past(serial_data_in)
        && rx_sh_r[7:1] == $past(rx_sh_r[6:0])))
        else $error("serial input not shifted in");

    chk_echo_out: assert property (@(posedge host_clk) disable iff (serial_enable_n)
        (fc_r == hcp_pkg::BIT_FULL && mode_r) |-> (host_data_o == rx_sh_r[7]))
        else $error("echo not on output");

    cov_fw_frame: cover property (@(posedge mclk) disable iff (!reset_n)
        fw_got);
    cov_i2c_write: cover property (@(posedge mclk) disable iff (!reset_n)
        i2c_got);
    cov_i2c_read: cover property (@(posedge mclk) disable iff (!reset_n)
        st_r == hcp_pkg::HCP_RDAT);
    cov_long_frame: cover property (@(posedge host_clk) disable iff (serial_enable_n)
        fc_r == hcp_pkg::BIT_FULL);

endmodule

`default_nettype wire

// >>> bench/hcp_host_model.sv
`default_nettype none

module hcp_host_model (
    input wire logic dev_data, // resolved level of the shared data pin
    output logic h_clk, // link clock, parked outside frames
    output logic h_sdi, // serial input, strap bit 1 in two-wire mode
    output logic h_en_n, // serial enable, strap bit 2 in two-wire mode
    output logic h_sda // host pull on two-wire data, high releases
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 32;

    logic [15:0] seen;

    ////////////////////////////////////////////////////////////////////////
    task automatic idle4();
        h_clk = 1'b0;
        h_sdi = 1'b0;
        h_en_n = 1'b1;
        h_sda = 1'b1;
    endtask

    // in two-wire mode the serial pins become address straps
    task automatic idle2(input logic s1, input logic s2);
        h_clk = 1'b1;
        h_sda = 1'b1;
        h_sdi = s1;
        h_en_n = s2;
    endtask

    // output sampled just before each rise, after the device's fall update
    task automatic frame4(input int n, input logic [15:0] tx);
        #7;
        h_en_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            h_sdi = tx[i];
            #HALF;
            seen = {seen[14:0], dev_data};
            h_clk = 1'b1;
            #HALF;
            h_clk = 1'b0;
        end
        #HALF;
        h_en_n = 1'b1;
        // a deselected input does not keep its last level
        h_sdi = ~h_sdi;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic start2(input int hp);
        #7;
        h_sda = 1'b0;
        #hp;
        h_clk = 1'b0;
        #50;
    endtask

    // data moves 50 ns after the clock fall so the device never sees a false start
    task automatic byte2(input int hp, input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            h_sda = b[i];
            #hp;
            // device read bits settle on the clock fall, so the rise sees them
            seen = {seen[14:0], dev_data};
            h_clk = 1'b1;
            #hp;
            h_clk = 1'b0;
            #50;
        end
        h_sda = 1'b1;
        #hp;
        h_clk = 1'b1;
        ack = dev_data;
        #hp;
        h_clk = 1'b0;
        #50;
    endtask

    task automatic stop2(input int hp);
        h_sda = 1'b0;
        #hp;
        h_clk = 1'b1;
        #hp;
        h_sda = 1'b1;
        #hp;
    endtask
endmodule

`default_nettype wire

// >>> bench/hcp_host_port_tb.sv
`default_nettype none

module hcp_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, reset_n, host_bus_select, host_clk, serial_data_in, serial_enable_n;
    logic host_data_i, host_data_o, host_data_oe_n, cmd_valid, cmd_known, mode_4wire;
    logic sda_host, ack;
    logic [7:0] rsp_byte, cmd_byte, cmd_func, adr;
    int n_errors, check_count, n_valid;

    // released pin is pulled high
    assign host_data_i = (host_data_oe_n ? 1'b1 : host_data_o) & sda_host;

    hcp_host_port hcp_host_port_inst (.mclk, .reset_n, .host_bus_select, .host_clk,
        .host_data_i, .host_data_o, .host_data_oe_n, .serial_data_in, .serial_enable_n,
        .rsp_byte, .cmd_valid, .cmd_byte, .cmd_known, .cmd_func, .mode_4wire);

    hcp_host_model hcp_host_model_inst (.dev_data(host_data_i), .h_clk(host_clk),
        .h_sdi(serial_data_in), .h_en_n(serial_enable_n), .h_sda(sda_host));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_cmd(input logic [7:0] exp, input int n0);
        logic known;
        known = exp >= hcp_pkg::CMD_BASE && exp < hcp_pkg::CMD_BASE + hcp_pkg::CMD_COUNT;
        chk_byte("deliveries", 8'h01, 8'(n_valid - n0));
        chk_byte("cmd_byte", exp, cmd_byte);
        chk_bit("cmd_known", known, cmd_known);
        if (known) chk_byte("cmd_func", exp - hcp_pkg::CMD_BASE, cmd_func);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hold is longer than the minimum so the pin synchronisers settle
    task automatic do_reset(input logic sel);
        @(posedge mclk);
        host_bus_select <= sel;
        reset_n <= 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask

    task automatic run4(input logic [7:0] rsp, input int n, input logic [15:0] tx);
        @(posedge mclk);
        rsp_byte <= rsp;
        repeat (3) @(posedge mclk);
        hcp_host_model_inst.frame4(n, tx);
        repeat (12) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_full4();
        int n0;
        n0 = n_valid;
        run4(8'hA6, 8, 16'h0019);
        chk_bit("mode_4wire", 1'b1, mode_4wire);
        chk_bit("oe_n", 1'b0, host_data_oe_n);
        chk_byte("out bits", 8'hA6, hcp_host_model_inst.seen[7:0]);
        chk_cmd(8'h19, n0);
        $display("full four-wire frame done");
    endtask

    task automatic test_short4();
        int n0;
        n0 = n_valid;
        run4(8'h5A, 0, 16'h0000);
        chk_byte("empty frame", 8'h00, 8'(n_valid - n0));
        n0 = n_valid;
        run4(8'h5A, 3, 16'h0005);
        chk_byte("short out", 8'h02, {5'h00, hcp_host_model_inst.seen[2:0]});
        chk_cmd(8'h05, n0);
        $display("short four-wire frame done");
    endtask

    task automatic test_long4();
        int n0;
        n0 = n_valid;
        run4(8'h3C, 12, 16'h0E1A);
        chk_byte("long out", 8'h3C, hcp_host_model_inst.seen[11:4]);
        chk_byte("echo", 8'h0E, {4'h0, hcp_host_model_inst.seen[3:0]});
        chk_cmd(8'h1A, n0);
        $display("long four-wire frame done");
    endtask

    task automatic i2c_xfer(input int hp, input int nb, input logic [23:0] b,
                            input logic [2:0] exp_ack);
        hcp_host_model_inst.start2(hp);
        for (int i = 0; i < nb; i++) begin
            hcp_host_model_inst.byte2(hp, b[23 - 8 * i -: 8], ack);
            chk_bit("ack", exp_ack[2 - i], ack);
        end
        hcp_host_model_inst.stop2(hp);
        repeat (10) @(posedge mclk);
    endtask

    task automatic test_i2c();
        int n0;
        hcp_host_model_inst.idle2(1'b1, 1'b1);
        do_reset(1'b0);
        chk_bit("mode_4wire", 1'b0, mode_4wire);
        chk_bit("oe_n idle", 1'b1, host_data_oe_n);
        adr = {hcp_pkg::I2C_ADDR_HI, 1'b1, 1'b1, hcp_pkg::I2C_ADDR_B0, hcp_pkg::RW_WRITE};
        n0 = n_valid;
        i2c_xfer(1250, 2, {adr, 8'h0C, 8'h00}, 3'b000);
        chk_cmd(8'h0C, n0);
        // strap bit 1 flipped: someone else's address
        n0 = n_valid;
        i2c_xfer(5000, 2, {adr ^ 8'h04, 8'h07, 8'h00}, 3'b110);
        chk_byte("foreign addr", 8'h00, 8'(n_valid - n0));
        n0 = n_valid;
        i2c_xfer(5000, 3, {adr, 8'h09, 8'h0A}, 3'b001);
        chk_cmd(8'h09, n0);
        rsp_byte <= 8'h93;
        n0 = n_valid;
        i2c_xfer(1250, 2, {adr[7:1], ~hcp_pkg::RW_WRITE, 8'hFF, 8'h00}, 3'b010);
        chk_byte("read byte", 8'h93, hcp_host_model_inst.seen[7:0]);
        chk_byte("read deliveries", 8'h00, 8'(n_valid - n0));
        $display("two-wire transactions done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        host_bus_select = 1'b1;
        rsp_byte = 8'h00;
        hcp_host_model_inst.idle4();
        do_reset(1'b1);
        test_full4();
        test_short4();
        test_long4();
        test_i2c();
        report_and_stop();
    end

    // the two-wire part at the slow rate dominates, about 0.6 ms
    initial begin
        #900000;
        n_errors++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end
endmodule

`default_nettype wire
